// ---- hdl/synth_prog_pkg.sv ----
// Purpose: Shared constants and types for the serial programming front end.
// Assumes: One 200 MHz system clock; serial pins arrive asynchronously.
// Notes: Field positions are given within the 18-bit serial word.
package synth_prog_pkg;
  localparam int WORD_W = 18;
  localparam int PAYLOAD_W = 16;
  localparam int SEL_LSB = 0;
  localparam int SEL_MSB = 1;
  localparam int PAY_LSB = 2;
  localparam int PAY_MSB = 17;
  localparam int UPPER_LSB = 14;
  localparam int UPPER_MSB = 17;
  localparam int RATIO_LSB = 2;
  localparam int RATIO_MSB = 13;
  localparam int BCNT_LSB = 6;
  localparam int BCNT_MSB = 17;
  localparam int ACNT_LSB = 2;
  localparam int ACNT_MSB = 5;
  localparam int ACNT_NARROW_MSB = 4;
  localparam int CP_SEC_GAIN = 17;
  localparam int CP_PRI_GAIN = 16;
  localparam int CP_SEC_POL = 15;
  localparam int CP_PRI_POL = 14;
  localparam int RATIO_W = 12;
  localparam int SWALLOW_W = 4;
  localparam int SYNC_STAGES = 3;
  localparam logic [4:0] PRESCALE_NARROW = 5'h08;
  localparam logic [4:0] PRESCALE_WIDE = 5'h10;
  localparam logic [1:0] SEL_SEC_REF = 2'h0;
  localparam logic [1:0] SEL_SEC_FB = 2'h1;
  localparam logic [1:0] SEL_PRI_REF = 2'h2;
  localparam logic [1:0] SEL_PRI_FB = 2'h3;
  localparam logic [15:0] LATCH_RESET = 16'h0000;
  localparam logic [17:0] WORD_RESET = 18'h00000;
  localparam logic [2:0] SYNC_RESET = 3'h0;
  typedef enum logic [3:0] {
    LS_REF_SEC = 4'h1,
    LS_FB_SEC = 4'h2,
    LS_REF_PRI = 4'h4,
    LS_FB_PRI = 4'h8
  } latch_sel_t;
endpackage

// ---- hdl/latch_bus_if.sv ----
// Purpose: Carries one latch write from the serial front end to the latch bank.
// Assumes: All signals on the system clock.
// Notes: Write is a one-cycle pulse.
interface latch_bus_if;
  logic wr;
  synth_prog_pkg::latch_sel_t sel;
  logic [15:0] payload;
  logic [15:0] sec_ref;
  logic [15:0] sec_fb;
  logic [15:0] pri_ref;
  logic [15:0] pri_fb;
  modport front(output wr, output sel, output payload,
                input sec_ref, input sec_fb, input pri_ref, input pri_fb);
  modport bank(input wr, input sel, input payload,
               output sec_ref, output sec_fb, output pri_ref, output pri_fb);
endinterface

// ---- hdl/latch_bank.sv ----
// Purpose: Holds the four 16-bit program latches.
// Assumes: One write pulse per committed word.
// Notes: Exactly one latch changes per write.
module latch_bank (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  latch_bus_if.bank lb
);
  logic [15:0] lat_q [4];

  // ****************************************
  // Latch storage
  // ****************************************
  for (genvar g = 0; g < 4; g++) begin : g_lat
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
        lat_q[g] <= synth_prog_pkg::LATCH_RESET;
      end else if (lb.wr && lb.sel[g]) begin
        lat_q[g] <= lb.payload;
      end
    end
  end

  assign lb.sec_ref = lat_q[0];
  assign lb.sec_fb = lat_q[1];
  assign lb.pri_ref = lat_q[2];
  assign lb.pri_fb = lat_q[3];
endmodule

// ---- hdl/dual_synth_serial_program_regs.sv ----
// Purpose: Serial programming front end with latches and divider reload.
// Assumes: Serial clock, data and load strobe are asynchronous pins.
// Notes: Divider counters are stepped by per-loop tick inputs.

// How it works
// - 18-bit word: 16 payload, 2 select
// - Shifted in MSB first, select last
// - Load strobe rise writes one latch
// - Select 00,01,10,11 picks the latch
// - Code 00: output select, secondary ratio
// - Reference ratios binary, 2 to 4095
// - Code 10: pump word, primary ratio
// - Pump word drives gain and polarity
// - Code 01: main count, swallow count
// - Secondary feedback supports both prescaler option ranges
// - Wide option: swallow 0 to 15
// - Narrow option: swallow top bit ignored
// - Data sampled on serial clock rise
// - New values load when counter hits zero
// - Pump word bits map gains and polarities
// - Divide by P+1 A times, P rest
module dual_synth_serial_program_regs (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_serial_clk,
  input wire logic i_serial_data,
  input wire logic i_load_strobe,
  input wire logic i_narrow_prescaler,
  input wire logic i_sec_ref_tick,
  input wire logic i_pri_ref_tick,
  input wire logic i_sec_fb_tick,
  output logic [3:0] o_multifunction_output_select,
  output logic [11:0] o_secondary_reference_ratio,
  output logic [11:0] o_primary_reference_ratio,
  output logic [3:0] o_pump_control_word,
  output logic o_secondary_pump_gain,
  output logic o_primary_pump_gain,
  output logic o_secondary_detector_polarity,
  output logic o_primary_detector_polarity,
  output logic [11:0] o_secondary_main_count,
  output logic [3:0] o_secondary_swallow_count,
  output logic [15:0] o_primary_feedback_latch,
  output logic o_sec_ref_out,
  output logic o_pri_ref_out,
  output logic o_sec_fb_out,
  output logic o_sec_fb_modulus_high
);
  logic [2:0] sclk_sync_q;
  logic [2:0] sdat_sync_q;
  logic [2:0] le_sync_q;
  logic [17:0] shift_q;
  logic sclk_lvl_q;
  logic sdat_lvl_q;
  logic le_lvl_q;
  logic sclk_rise;
  logic le_rise;
  logic [11:0] sec_ref_cnt_q;
  logic [11:0] pri_ref_cnt_q;
  logic [11:0] b_cnt_q;
  logic [3:0] a_cnt_q;
  logic [4:0] p_cnt_q;
  logic sec_ref_out_q;
  logic pri_ref_out_q;
  logic sec_fb_out_q;
  logic [4:0] p_top;
  logic [3:0] a_eff;

  latch_bus_if lb ();

  latch_bank u_bank (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .lb(lb)
  );

  function automatic synth_prog_pkg::latch_sel_t decode_sel(input logic [1:0] s);
    case (s)
      synth_prog_pkg::SEL_SEC_REF: decode_sel = synth_prog_pkg::LS_REF_SEC;
      synth_prog_pkg::SEL_SEC_FB: decode_sel = synth_prog_pkg::LS_FB_SEC;
      synth_prog_pkg::SEL_PRI_REF: decode_sel = synth_prog_pkg::LS_REF_PRI;
      default: decode_sel = synth_prog_pkg::LS_FB_PRI;
    endcase
  endfunction

  // Ratios 0 and 1 both divide by one.
  function automatic logic [11:0] reload_count(input logic [11:0] r);
    reload_count = (r <= 12'h001) ? 12'h000 : r - 12'h001;
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sclk_sync_q <= synth_prog_pkg::SYNC_RESET;
      sdat_sync_q <= synth_prog_pkg::SYNC_RESET;
      le_sync_q <= synth_prog_pkg::SYNC_RESET;
    end else begin
      sclk_sync_q <= {sclk_sync_q[1:0], i_serial_clk};
      sdat_sync_q <= {sdat_sync_q[1:0], i_serial_data};
      le_sync_q <= {le_sync_q[1:0], i_load_strobe};
    end
  end

  // ****************************************
  // Settled pin levels
  // ****************************************
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sclk_lvl_q <= 1'b0;
      sdat_lvl_q <= 1'b0;
      le_lvl_q <= 1'b0;
    end else begin
      if (sclk_sync_q[2] == sclk_sync_q[1]) begin
        sclk_lvl_q <= sclk_sync_q[2];
      end
      if (sdat_sync_q[2] == sdat_sync_q[1]) begin
        sdat_lvl_q <= sdat_sync_q[2];
      end
      if (le_sync_q[2] == le_sync_q[1]) begin
        le_lvl_q <= le_sync_q[2];
      end
    end
  end

  // An edge counts once stages two and three agree on a new level.
  assign sclk_rise = sclk_sync_q[2] && sclk_sync_q[1] && !sclk_lvl_q;
  assign le_rise = le_sync_q[2] && le_sync_q[1] && !le_lvl_q;

  // ****************************************
  // Shift register
  // ****************************************
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      shift_q <= synth_prog_pkg::WORD_RESET;
    end else if (sclk_rise) begin
      shift_q <= {shift_q[16:0], sdat_lvl_q};
    end
  end

  // ****************************************
  // Latch write on load strobe
  // ****************************************
  assign lb.wr = le_rise;
  assign lb.sel = decode_sel(shift_q[synth_prog_pkg::SEL_MSB:synth_prog_pkg::SEL_LSB]);
  assign lb.payload = shift_q[synth_prog_pkg::PAY_MSB:synth_prog_pkg::PAY_LSB];

  // Latch fields, payload bit k is word bit k+2.
  assign o_multifunction_output_select = lb.sec_ref[15:12];
  assign o_secondary_reference_ratio = lb.sec_ref[11:0];
  assign o_pump_control_word = lb.pri_ref[15:12];
  assign o_primary_reference_ratio = lb.pri_ref[11:0];
  assign o_secondary_pump_gain = lb.pri_ref[15];
  assign o_primary_pump_gain = lb.pri_ref[14];
  assign o_secondary_detector_polarity = lb.pri_ref[13];
  assign o_primary_detector_polarity = lb.pri_ref[12];
  assign o_secondary_main_count = lb.sec_fb[15:4];
  assign o_secondary_swallow_count = lb.sec_fb[3:0];
  assign o_primary_feedback_latch = lb.pri_fb;

  // ****************************************
  // Reference dividers
  // ****************************************
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sec_ref_cnt_q <= 12'h000;
      sec_ref_out_q <= 1'b0;
    end else begin
      sec_ref_out_q <= 1'b0;
      if (i_sec_ref_tick) begin
        if (sec_ref_cnt_q == 12'h000) begin
          sec_ref_cnt_q <= reload_count(o_secondary_reference_ratio);
          sec_ref_out_q <= 1'b1;
        end else begin
          sec_ref_cnt_q <= sec_ref_cnt_q - 12'h001;
        end
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pri_ref_cnt_q <= 12'h000;
      pri_ref_out_q <= 1'b0;
    end else begin
      pri_ref_out_q <= 1'b0;
      if (i_pri_ref_tick) begin
        if (pri_ref_cnt_q == 12'h000) begin
          pri_ref_cnt_q <= reload_count(o_primary_reference_ratio);
          pri_ref_out_q <= 1'b1;
        end else begin
          pri_ref_cnt_q <= pri_ref_cnt_q - 12'h001;
        end
      end
    end
  end

  // ****************************************
  // Secondary feedback pulse-swallow divider
  // ****************************************
  assign p_top = i_narrow_prescaler ? synth_prog_pkg::PRESCALE_NARROW
                                    : synth_prog_pkg::PRESCALE_WIDE;
  assign a_eff = i_narrow_prescaler ? {1'b0, o_secondary_swallow_count[2:0]}
                                    : o_secondary_swallow_count;

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      p_cnt_q <= 5'h00;
      a_cnt_q <= 4'h0;
      b_cnt_q <= 12'h000;
      sec_fb_out_q <= 1'b0;
    end else begin
      sec_fb_out_q <= 1'b0;
      if (i_sec_fb_tick) begin
        // Prescaler counts P+1 while swallowing, else P.
        if (p_cnt_q != 5'h00) begin
          p_cnt_q <= p_cnt_q - 5'h01;
        end else if (b_cnt_q <= 12'h001) begin
          b_cnt_q <= o_secondary_main_count;
          a_cnt_q <= a_eff;
          p_cnt_q <= (a_eff != 4'h0) ? p_top : p_top - 5'h01;
          sec_fb_out_q <= 1'b1;
        end else begin
          b_cnt_q <= b_cnt_q - 12'h001;
          if (a_cnt_q != 4'h0) begin
            a_cnt_q <= a_cnt_q - 4'h1;
          end
          p_cnt_q <= (a_cnt_q > 4'h1) ? p_top : p_top - 5'h01;
        end
      end
    end
  end

  assign o_sec_fb_modulus_high = (a_cnt_q != 4'h0);
  assign o_sec_ref_out = sec_ref_out_q;
  assign o_pri_ref_out = pri_ref_out_q;
  assign o_sec_fb_out = sec_fb_out_q;
endmodule

// ---- dv/dual_synth_serial_program_regs_properties.sv ----
// Purpose: Port checks for the serial program front end.
// Assumes: One system clock domain, reset active high.
// Notes: Bound into the top module.
module dual_synth_serial_program_regs_properties (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_load_strobe,
  input wire logic i_sec_ref_tick,
  input wire logic i_sec_fb_tick,
  input wire logic [3:0] o_pump_control_word,
  input wire logic o_secondary_pump_gain,
  input wire logic o_primary_pump_gain,
  input wire logic o_secondary_detector_polarity,
  input wire logic o_primary_detector_polarity,
  input wire logic [11:0] o_secondary_reference_ratio,
  input wire logic [11:0] o_secondary_main_count,
  input wire logic o_sec_ref_out,
  input wire logic o_sec_fb_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);
  a_sec_gain_map: assert property (o_secondary_pump_gain == o_pump_control_word[3])
    else $error("secondary gain bit wrong");
  a_pri_gain_map: assert property (o_primary_pump_gain == o_pump_control_word[2])
    else $error("primary gain bit wrong");
  a_sec_pol_map: assert property (o_secondary_detector_polarity == o_pump_control_word[1])
    else $error("secondary polarity bit wrong");
  a_pri_pol_map: assert property (o_primary_detector_polarity == o_pump_control_word[0])
    else $error("primary polarity bit wrong");
  a_ratio_held_quiet: assert property ($changed(o_secondary_reference_ratio) |-> $past(i_load_strobe, 3))
    else $error("reference ratio changed without strobe");
  a_count_held_quiet: assert property ($changed(o_secondary_main_count) |-> $past(i_load_strobe, 3))
    else $error("main count changed without strobe");
  a_ref_pulse_cause: assert property (o_sec_ref_out |-> $past(i_sec_ref_tick))
    else $error("reference pulse without tick");
  a_fb_pulse_cause: assert property (o_sec_fb_out |-> $past(i_sec_fb_tick))
    else $error("feedback pulse without tick");
  c_strobe: cover property ($rose(i_load_strobe));
  c_ref_pulse: cover property (o_sec_ref_out);
  c_fb_pulse: cover property (o_sec_fb_out);
endmodule

bind dual_synth_serial_program_regs dual_synth_serial_program_regs_properties props_inst (.*);

// ---- dv/host_serial_model.sv ----
// Purpose: Host that shifts words and raises the load strobe.
// Assumes: Serial clock of 64 ns, still outside frames.
// Notes: Data line shows the inverse of its last bit when idle.
module host_serial_model (
  input wire logic i_mclk,
  output logic o_serial_clk,
  output logic o_serial_data,
  output logic o_load_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_serial_clk = 1'b0;
    o_serial_data = 1'b0;
    o_load_strobe = 1'b0;
  end
  // Shifts one whole word, first bit the top one.
  task automatic shift_word(input logic [17:0] w);
    @(posedge i_mclk);
    #1.5;
    for (int i = 17; i >= 0; i--) begin
      o_serial_data = w[i];
      #32 o_serial_clk = 1'b1;
      #32 o_serial_clk = 1'b0;
    end
    o_serial_data = ~o_serial_data;
  endtask
  // Raises the strobe once the shifting is over.
  task automatic load_word();
    #32 o_load_strobe = 1'b1;
    #64 o_load_strobe = 1'b0;
  endtask
endmodule

// ---- dv/dual_synth_serial_program_regs_test.sv ----
// Purpose: Self-checking bench for the serial program front end.
// Assumes: 200 MHz system clock, host model drives the pins.
// Notes: Latch outputs are read after a fixed settle.
module dual_synth_serial_program_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk = 1'b0, i_sys_rst = 1'b1, i_narrow_prescaler = 1'b0;
  logic i_sec_ref_tick = 1'b0, i_pri_ref_tick = 1'b1, i_sec_fb_tick = 1'b0;
  logic sclk, sdata, strobe, sg, pg, sp, pp, sro, pro, sfo, mh;
  logic [3:0] mux, pump, swal;
  logic [11:0] sref, pref, mcnt;
  logic [15:0] pfb;
  int bad_count = 0, cmp_count = 0, n = 0, m = 0, k = 0;
  initial forever #2.5 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    #1 i_sec_ref_tick = ~i_sec_ref_tick;
    i_pri_ref_tick = ~i_pri_ref_tick;
    i_sec_fb_tick = ~i_sec_fb_tick;
  end
  host_serial_model host_serial_model_inst (.i_mclk(i_mclk), .o_serial_clk(sclk),
    .o_serial_data(sdata), .o_load_strobe(strobe));
  dual_synth_serial_program_regs dual_synth_serial_program_regs_inst (.i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst), .i_serial_clk(sclk), .i_serial_data(sdata),
    .i_load_strobe(strobe), .i_narrow_prescaler(i_narrow_prescaler),
    .i_sec_ref_tick(i_sec_ref_tick), .i_pri_ref_tick(i_pri_ref_tick),
    .i_sec_fb_tick(i_sec_fb_tick), .o_multifunction_output_select(mux),
    .o_secondary_reference_ratio(sref), .o_primary_reference_ratio(pref),
    .o_pump_control_word(pump), .o_secondary_pump_gain(sg), .o_primary_pump_gain(pg),
    .o_secondary_detector_polarity(sp), .o_primary_detector_polarity(pp),
    .o_secondary_main_count(mcnt), .o_secondary_swallow_count(swal),
    .o_primary_feedback_latch(pfb), .o_sec_ref_out(sro), .o_pri_ref_out(pro),
    .o_sec_fb_out(sfo), .o_sec_fb_modulus_high(mh));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [17:0] w);
    host_serial_model_inst.shift_word(w);
    host_serial_model_inst.load_word();
    repeat (8) @(posedge i_mclk);
    #1;
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ****************************************
  // Test sequence.
  // ****************************************
  initial begin
    repeat (16) @(posedge i_mclk);
    #1 i_sys_rst = 1'b0;
    check(16'(sref), 16'h0000);
    wr({4'h9, 12'h5a3, 2'h0});
    check(16'(mux), 16'h0009);
    check(16'(sref), 16'h05a3);
    check(16'(pref), 16'h0000);
    $display("test aux reference done");
    wr({4'ha, 12'h005, 2'h2});
    check(16'(pump), 16'h000a);
    check(16'({sg, pg, sp, pp}), 16'h000a);
    check(16'(pref), 16'h0005);
    check(16'(sref), 16'h05a3);
    $display("test main reference done");
    i_narrow_prescaler = 1'b1;
    wr({12'h010, 4'hd, 2'h1});
    check(16'(mcnt), 16'h0010);
    check(16'(swal), 16'h000d);
    wr({16'hbeef, 2'h3});
    check(pfb, 16'hbeef);
    check(16'(mcnt), 16'h0010);
    n = 0;
    while (sfo !== 1'b1 && n < 1000) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    n = 0;
    m = 0;
    do begin
      @(posedge i_mclk);
      #1;
      n++;
      if (mh === 1'b1) m++;
    end while (sfo !== 1'b1 && n < 1000);
    check(16'(n), 16'h010a);
    check(16'(m), 16'h005a);
    $display("test feedback done");
    host_serial_model_inst.shift_word(18'h3ffff);
    wr({4'h5, 12'h003, 2'h0});
    check(16'(mux), 16'h0005);
    check(16'(sref), 16'h0003);
    repeat (3000) @(posedge i_mclk);
    n = 0;
    k = 0;
    repeat (60) begin
      @(posedge i_mclk);
      #1;
      if (sro === 1'b1) n++;
      if (pro === 1'b1) k++;
    end
    check(16'(n), 16'h000a);
    check(16'(k), 16'h0006);
    $display("test extra bits and ratio done");
    end_sim();
  end
  initial begin
    #100us;
    bad_count++;
    end_sim();
  end
endmodule
